// File: src/epw_consts.svh
// offsets, field positions, reset values and widths of the pwm restart/steering block
`ifndef EPW_CONSTS_SVH
`define EPW_CONSTS_SVH

// register byte offsets on apb
`define EPW_OFF_RESTART_CTRL 12'h000
`define EPW_OFF_STEER_CTRL 12'h004
`define EPW_OFF_MODE_CTRL 12'h008
`define EPW_OFF_SHUT_STATUS 12'h00c
`define EPW_OFF_IRQ_STATUS 12'h010
`define EPW_OFF_IRQ_MASK 12'h014

// restart/deadband control fields
`define EPW_RESTART_EN_BIT 7
`define EPW_DELAY_MSB 6
`define EPW_RESTART_CTRL_RST 8'h00

// steering control fields
`define EPW_STEER_SYNC_BIT 4
`define EPW_STEER_IMPL_MASK 8'h1f
`define EPW_STEER_CTRL_RST 8'h01

// mode control fields: output configuration 7:6, capture/compare mode 3:0
`define EPW_MODE_CFG_MSB 7
`define EPW_MODE_CFG_LSB 6
`define EPW_MODE_PWM_SEL 2'h3
`define EPW_CFG_SINGLE 2'h0
`define EPW_CFG_HALF 2'h2
`define EPW_MODE_CTRL_RST 8'h00

// interrupt status bits
`define EPW_IRQ_SHUTDOWN 0
`define EPW_IRQ_RESUME 1
`define EPW_IRQ_W 2

`define EPW_DELAY_W 7
`define EPW_NCH 2

`endif

// File: src/epw_pkg.sv
// types of the pwm restart/steering block
package epw_pkg;

  typedef enum logic [2:0] {
    EPW_ST_RUN  = 3'b001,
    EPW_ST_SHUT = 3'b010,
    EPW_ST_WAIT = 3'b100
  } epw_state_t;

  typedef struct packed {
    logic [6:0] cnt;
  } epw_db_state_t;

  typedef struct packed {
    logic shut_meta;
    logic shut_sync;
    logic [7:0] restart_ctrl;
    logic [7:0] steer_ctrl;
    logic [7:0] mode_ctrl;
    logic [3:0] steer_eff;
    epw_state_t state;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [3:0] pin_out;
    logic [3:0] pin_sel;
  } epw_state_all_t;

endpackage

// File: src/epw_deadband.sv
// delays the rising edge of one pwm channel by a programmable count
`timescale 1ns/10ps
`include "epw_consts.svh"

module epw_deadband (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // channel
  input wire logic sig_in,
  input wire logic [6:0] delay,
  output logic sig_out
);

  epw_pkg::epw_db_state_t q;
  epw_pkg::epw_db_state_t d;

  always_comb begin
    d = q;
    // falling edges pass at once, rising edges wait for the count
    if (!sig_in) begin
      d.cnt = 7'h00;
    end else if (q.cnt < delay) begin
      d.cnt = q.cnt + 7'h01;
    end
  end

  // zero delay passes the edge unchanged
  assign sig_out = sig_in && (q.cnt >= delay);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// File: src/epw_top.sv
// pwm output stage: auto-restart, dead-band and pulse steering with apb registers
//
// Behaviour
// - restart enable set: pwm resumes by itself once shutdown input goes away
// - with restart enabled, shutdown status follows the shutdown condition
// - restart disabled: outputs stay shut until software clears shutdown status
// - half-bridge dead-band delays only inactive-to-active edges
// - seven-bit delay count gives the delay in instruction cycles
// - steering works only for pwm mode 11 with output configuration 00
// - each steer enable puts pwm on its pin, else pin is port
// - same waveform may appear on any combination of the four pins
// - low two mode bits set polarity of all steered pins
// - shutdown forces only steered pins into shutdown state
// - steer sync one: update at period start; zero: at next cycle
// - steering control bits 7 to 5 read as zero
// - writes to shutdown status ignored while shutdown condition persists
// - after restart, output resumes at the next pwm period start
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "epw_consts.svh"

module epw_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pwm source, same clock
  input wire logic pwm_in,
  input wire logic period_start,
  // auto-shutdown condition, asynchronous level
  input wire logic shutdown_in,
  // output pins
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  // high where the pin carries pwm rather than port function
  output logic [3:0] pwm_pin_sel,
  // interrupt
  output logic irq
);

  epw_pkg::epw_state_all_t q;
  epw_pkg::epw_state_all_t d;

  logic [`EPW_NCH-1:0] db_in;
  logic [`EPW_NCH-1:0] db_out;
  logic wr;
  logic hit;
  logic pwm_mode;
  logic single_mode;
  logic half_mode;
  logic shut;
  logic [3:0] pol;
  logic [1:0] cfg;
  logic [31:0] rdata;

  // channel a sees the pwm, channel b its complement
  assign db_in = {~pwm_in, pwm_in};

  genvar gi;
  generate
    for (gi = 0; gi < `EPW_NCH; gi = gi + 1) begin : g_db
      epw_deadband u_db (
        .pclk(pclk),
        .presetn(presetn),
        .sig_in(db_in[gi]),
        .delay(q.restart_ctrl[`EPW_DELAY_MSB:0]),
        .sig_out(db_out[gi])
      );
    end
  endgenerate

  assign wr = psel && penable && pwrite;
  assign cfg = q.mode_ctrl[`EPW_MODE_CFG_MSB:`EPW_MODE_CFG_LSB];
  assign pwm_mode = (q.mode_ctrl[3:2] == `EPW_MODE_PWM_SEL);
  assign single_mode = pwm_mode && (cfg == `EPW_CFG_SINGLE);
  assign half_mode = pwm_mode && (cfg == `EPW_CFG_HALF);
  assign shut = (q.state != epw_pkg::EPW_ST_RUN);
  // bit 1 inverts pins a and c, bit 0 inverts pins b and d
  assign pol = {q.mode_ctrl[0], q.mode_ctrl[1], q.mode_ctrl[0], q.mode_ctrl[1]};

  // read mux, zero wait states
  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `EPW_OFF_RESTART_CTRL: rdata[7:0] = q.restart_ctrl;
      `EPW_OFF_STEER_CTRL: rdata[7:0] = q.steer_ctrl & `EPW_STEER_IMPL_MASK;
      `EPW_OFF_MODE_CTRL: rdata[7:0] = q.mode_ctrl;
      `EPW_OFF_SHUT_STATUS: rdata[0] = (q.state == epw_pkg::EPW_ST_SHUT);
      `EPW_OFF_IRQ_STATUS: rdata[1:0] = q.irq_stat;
      `EPW_OFF_IRQ_MASK: rdata[1:0] = q.irq_mask;
      default: hit = 1'b0;
    endcase
  end

  assign prdata = rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    d = q;
    // two flops before the pin is read
    d.shut_meta = shutdown_in;
    d.shut_sync = q.shut_meta;

    // register writes
    if (wr && paddr == `EPW_OFF_RESTART_CTRL) begin
      d.restart_ctrl = pwdata[7:0];
    end
    if (wr && paddr == `EPW_OFF_STEER_CTRL) begin
      d.steer_ctrl = pwdata[7:0] & `EPW_STEER_IMPL_MASK;
    end
    if (wr && paddr == `EPW_OFF_MODE_CTRL) begin
      d.mode_ctrl = pwdata[7:0];
    end
    if (wr && paddr == `EPW_OFF_IRQ_MASK) begin
      d.irq_mask = pwdata[1:0];
    end
    if (wr && paddr == `EPW_OFF_IRQ_STATUS) begin
      d.irq_stat = q.irq_stat & ~pwdata[1:0];
    end

    // shutdown / restart sequencing
    case (q.state)
      epw_pkg::EPW_ST_RUN: begin
        // software may also force a shutdown by writing a one
        if (q.shut_sync || (wr && paddr == `EPW_OFF_SHUT_STATUS && pwdata[0])) begin
          d.state = epw_pkg::EPW_ST_SHUT;
          d.irq_stat[`EPW_IRQ_SHUTDOWN] = 1'b1;
        end
      end
      epw_pkg::EPW_ST_SHUT: begin
        if (q.shut_sync) begin
          // status held while the level persists; writes have no effect
          d.state = epw_pkg::EPW_ST_SHUT;
        end else if (q.restart_ctrl[`EPW_RESTART_EN_BIT]) begin
          d.state = epw_pkg::EPW_ST_WAIT;
        end else if (wr && paddr == `EPW_OFF_SHUT_STATUS && !pwdata[0]) begin
          d.state = epw_pkg::EPW_ST_WAIT;
        end
      end
      epw_pkg::EPW_ST_WAIT: begin
        // a new shutdown beats the pending restart
        if (q.shut_sync) begin
          d.state = epw_pkg::EPW_ST_SHUT;
          d.irq_stat[`EPW_IRQ_SHUTDOWN] = 1'b1;
        end else if (period_start) begin
          d.state = epw_pkg::EPW_ST_RUN;
          d.irq_stat[`EPW_IRQ_RESUME] = 1'b1;
        end
      end
      default: d.state = epw_pkg::EPW_ST_SHUT;
    endcase

    // steering update; sync mode trades latency for whole pulses
    if (!q.steer_ctrl[`EPW_STEER_SYNC_BIT] || period_start) begin
      d.steer_eff = q.steer_ctrl[3:0];
    end

    // pin drive, shutdown state is low
    d.pin_out = 4'h0;
    d.pin_sel = 4'h0;
    if (single_mode) begin
      d.pin_sel = q.steer_eff;
      if (!shut) begin
        d.pin_out = ({4{pwm_in}} ^ pol) & q.steer_eff;
      end
      // unsteered pins keep port function, untouched by shutdown
      d.pin_out = d.pin_out & q.steer_eff;
    end else if (half_mode) begin
      d.pin_sel = 4'h3;
      if (!shut) begin
        d.pin_out[1:0] = db_out ^ pol[1:0];
      end
    end else if (pwm_mode) begin
      d.pin_sel = 4'h1;
      if (!shut) begin
        d.pin_out[0] = pwm_in ^ pol[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.shut_meta <= 1'b0;
      q.shut_sync <= 1'b0;
      q.restart_ctrl <= `EPW_RESTART_CTRL_RST;
      q.steer_ctrl <= `EPW_STEER_CTRL_RST;
      q.mode_ctrl <= `EPW_MODE_CTRL_RST;
      q.steer_eff <= 4'h1;
      q.state <= epw_pkg::EPW_ST_RUN;
      q.irq_stat <= 2'h0;
      q.irq_mask <= 2'h0;
      q.pin_out <= 4'h0;
      q.pin_sel <= 4'h0;
    end else begin
      q <= d;
    end
  end

  assign pwm_out_a = q.pin_out[0];
  assign pwm_out_b = q.pin_out[1];
  assign pwm_out_c = q.pin_out[2];
  assign pwm_out_d = q.pin_out[3];
  assign pwm_pin_sel = q.pin_sel;
  assign irq = |(q.irq_stat & q.irq_mask);

endmodule

// File: dv/epw_top_props.sv
// port assertions of the pwm restart/steering block
`timescale 1ns/10ps
module epw_top_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pwm side
  input wire logic period_start,
  input wire logic shutdown_in,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic pwm_out_c,
  input wire logic pwm_out_d,
  input wire logic [3:0] pwm_pin_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] pins;
  assign pins = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};
  // five edges cover the two sync flops, the state and the pin register
  sequence s_shut_held; shutdown_in [*5]; endsequence
  sequence s_no_period; !period_start [*8]; endsequence
  a_zero_wait: assert property (psel && penable |-> pready) else $error("apb wait state");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
    else $error("unmapped access accepted");
  a_unmapped_rd: assert property (pslverr |-> prdata == 32'h0) else $error("error read data");
  a_steer_top_zero: assert property (psel && penable && !pwrite && paddr == 12'h004
    |-> prdata[7:5] == 3'h0) else $error("steer upper bits not zero");
  a_sel_gate_ab: assert property ((pins[1:0] & ~pwm_pin_sel[1:0]) == 2'h0)
    else $error("port pin a or b driven");
  a_sel_gate_cd: assert property ((pins[3:2] & ~pwm_pin_sel[3:2]) == 2'h0)
    else $error("port pin c or d driven");
  a_shut_quiet: assert property (s_shut_held |-> pins == 4'h0)
    else $error("pins active in shutdown");
  a_resume_on_period: assert property (s_shut_held ##1 s_no_period |-> pins == 4'h0)
    else $error("resume before period start");
endmodule
bind epw_top epw_top_chk u_epw_top_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .period_start, .shutdown_in, .pwm_out_a, .pwm_out_b,
  .pwm_out_c, .pwm_out_d, .pwm_pin_sel);

// File: dv/epw_switch_model.sv
// half-bridge switch pair: flags both switches conducting together
`timescale 1ns/10ps
module epw_switch_model (
  // clock and arming
  input wire logic pclk,
  input wire logic arm,
  // gate drives
  input wire logic gate_hi,
  input wire logic gate_lo,
  // shoot-through seen
  output logic shoot
);
  initial shoot = 1'b0;
  // sticky, so one bad cycle is never lost
  always @(posedge pclk) if (arm && gate_hi && gate_lo) shoot <= 1'b1;
endmodule

// File: dv/tb_top.sv
// self-checking bench for the pwm restart/steering block
`timescale 1ns/10ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arm = 1'b0;
  logic pwm_in = 1'b0, period_start = 1'b0, shutdown_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d, irq, shoot, er;
  logic [3:0] pwm_pin_sel;
  logic [3:0] sv [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
  int num_errors = 0, comparisons = 0, cyc = 0, ls, l0, l3, lf;
  always #5 pclk = ~pclk;
  epw_top u_epw_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pwm_in, .period_start, .shutdown_in, .pwm_out_a, .pwm_out_b,
    .pwm_out_c, .pwm_out_d, .pwm_pin_sel, .irq);
  // the switches see a pin only while pwm_pin_sel marks it as carrying pwm
  epw_switch_model u_epw_switch_model (.pclk, .arm,
    .gate_hi(pwm_out_a && pwm_pin_sel[0]),
    .gate_lo(pwm_out_b && pwm_pin_sel[1]), .shoot);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk("prdata", exp, rd);
  endtask
  task automatic pulse();
    period_start <= 1'b1;
    @(posedge pclk);
    period_start <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // cycles from a pwm_in change until pin a follows
  task automatic lat(input logic v, output int n);
    pwm_in <= v;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      @(negedge pclk);
    end while (pwm_out_a !== v && n < 200);
    repeat (8) @(posedge pclk);
  endtask
  // samples mid-cycle, where the registered pins have settled
  task automatic chk_pins(input logic [3:0] exp_sel, input logic [3:0] exp_pin);
    @(negedge pclk);
    chk("pwm_pin_sel", {28'h0, exp_sel}, {28'h0, pwm_pin_sel});
    chk("pins", {28'h0, exp_pin}, {28'h0, pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a});
    @(posedge pclk);
  endtask
  task automatic chk_irq(input logic exp);
    @(negedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
    @(posedge pclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h1);
    rdc(12'h020, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    apb(12'h004, 1'b1, 32'hff);
    rdc(12'h004, 32'h1f);
    apb(12'h008, 1'b1, 32'h0c);
    pwm_in <= 1'b1;
    foreach (sv[i]) begin
      apb(12'h004, 1'b1, {28'h0, sv[i]});
      // unsynced steering lands one cycle after the write, the pins one later
      @(posedge pclk);
      chk_pins(sv[i], sv[i]);
    end
    apb(12'h008, 1'b1, 32'h0f);
    chk_pins(4'hf, 4'h0);
    apb(12'h008, 1'b1, 32'h0e);
    chk_pins(4'hf, 4'ha);
    apb(12'h008, 1'b1, 32'h4c);
    chk_pins(4'h1, 4'h1);
    apb(12'h008, 1'b1, 32'h0c);
    apb(12'h004, 1'b1, 32'h12);
    // the same wait that lets an unsynced update reach the pins
    @(posedge pclk);
    chk_pins(4'hf, 4'hf);
    pulse();
    chk_pins(4'h2, 4'h2);
    apb(12'h014, 1'b1, 32'h1);
    shutdown_in <= 1'b1;
    repeat (6) @(posedge pclk);
    chk_pins(4'h2, 4'h0);
    chk_irq(1'b1);
    apb(12'h00c, 1'b1, 32'h0);
    rdc(12'h00c, 32'h1);
    // restart is disabled, so the shutdown status must stay set after the level goes away
    shutdown_in <= 1'b0;
    repeat (12) @(posedge pclk);
    rdc(12'h00c, 32'h1);
    apb(12'h00c, 1'b1, 32'h0);
    rdc(12'h00c, 32'h0);
    apb(12'h010, 1'b1, 32'h3);
    chk_irq(1'b0);
    chk_pins(4'h2, 4'h0);
    pulse();
    chk_pins(4'h2, 4'h2);
    apb(12'h000, 1'b1, 32'h80);
    shutdown_in <= 1'b1;
    repeat (6) @(posedge pclk);
    rdc(12'h00c, 32'h1);
    shutdown_in <= 1'b0;
    repeat (5) @(posedge pclk);
    rdc(12'h00c, 32'h0);
    chk_pins(4'h2, 4'h0);
    pulse();
    chk_pins(4'h2, 4'h2);
    apb(12'h004, 1'b1, 32'h01);
    lat(1'b0, lf);
    lat(1'b1, ls);
    arm <= 1'b1;
    apb(12'h008, 1'b1, 32'h8c);
    lat(1'b0, lf);
    lat(1'b1, l0);
    chk("rise_delay", ls, l0);
    apb(12'h000, 1'b1, 32'h83);
    // a new count restarts the rise delay; let it settle while the pwm is high
    repeat (8) @(posedge pclk);
    lat(1'b0, lf);
    chk("fall_delay", ls, lf);
    lat(1'b1, l3);
    chk("rise_delay", ls + 3, l3);
    chk("shoot", 32'h0, {31'h0, shoot});
    // reset in mid-run brings every register back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h1);
    chk_pins(4'h0, 4'h0);
    report_and_stop();
  end
endmodule
